// >>> design/cpps_core.sv
// Converter protection and power-rail sequencer control
//
// Operation
// - Intermediate output over-voltage stops switching of both converters at once.
// - Intermediate over-current or under-voltage beyond mask enters protect operation.
// - Intermediate under-voltage and forwarded core detect masked 92us; over-current mask programmable.
// - Protect mode retries at programmed interval; returns to normal once fault clears.
// - Core or analog regulator over-voltage forces intermediate converter into protect.
// - Interrupt output goes low no later than the edge on which either converter enters protect.
// - Core over-current or under-voltage beyond mask: interval operation with own retry.
// - Core output over-voltage stops switching of both converters.
// - Optional core under-voltage reset: reset low at once while below threshold.
// - After core recovers from under-voltage reset, hold reset 12ms more.
// - Abnormal converter output sets a status flag and raises interrupt.
// - Retry fields 7:6 and 3:2 encode 15.6, 31.2, 124.9, 249.9ms.
// - Mask fields 5:4 and 1:0 encode 122, 122, 610, 1098us.
// - Timing register is not reinitialised by the reset output.
// - Housekeeping first, then others in fixed order; reset released after all up.
// - Enable starts diagnosis, then sequencing; interrupt released, reset 12ms later.
// - Enable tied to supply starts the same sequence when supply rises.
// - Keep-alive alone raises only housekeeping; full sequence waits for an enable.
// - Enable raised with supply below reset threshold does not start the sequence; it stays off or in keep-alive.
// - Enables dropped: assert interrupt and reset, then power down after reset low.
// - Falling supply: suspend warning at I/O first low, then reset and shutdown.
`timescale 1ns/100ps
`include "cpps_defines.svh"
module cpps_core
   import cpps_pkg::*;
#(
   parameter int RAIL_COUNT = 4,
   parameter int STEP_CYC = 40000,
   parameter int DIAG_CYC = 40000,
   parameter int RST_HOLD_CYC = `CPPS_RST_HOLD_CYC,
   parameter int RETRY0_CYC = `CPPS_RETRY0_CYC,
   parameter int RETRY1_CYC = `CPPS_RETRY1_CYC,
   parameter int RETRY2_CYC = `CPPS_RETRY2_CYC,
   parameter int RETRY3_CYC = `CPPS_RETRY3_CYC
) (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic power_enable_a_in,
   input wire logic power_enable_b_in,
   input wire logic keepalive_enable_in,
   input wire logic battery_supply_ok_in,
   input wire logic battery_above_reset_in,
   input wire logic io_first_low_level_in,
   input wire logic diag_pass_in,
   input wire logic uv_reset_enable_in,
   input wire logic inter_ov_in,
   input wire logic inter_oc_in,
   input wire logic inter_uv_in,
   input wire logic core_ov_in,
   input wire logic core_oc_in,
   input wire logic core_uv_in,
   input wire logic analog_ov_in,
   input wire logic reg_wr_in,
   input wire logic [5:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic status_clr_in,
   output logic [7:0] reg_rdata_out,
   output logic [1:0] fault_status_out,
   output logic inter_switch_en_out,
   output logic core_switch_en_out,
   output logic housekeeping_en_out,
   output logic [RAIL_COUNT-1:0] rail_en_out,
   output logic interrupt_out_n,
   output logic system_reset_out_n,
   output logic suspend_warning_n
);
   // ==========================================================
   // Timing register
   // ==========================================================
   logic [7:0] timing_q, timing_d;
   // Only the chip reset reloads it; the reset output never touches it
   always_comb begin
      timing_d = timing_q;
      if (reg_wr_in && reg_addr_in == `CPPS_TIMING_ADDR) begin
         timing_d = reg_wdata_in;
      end
   end
   always_ff @(posedge clk_in) begin
      if (!nrst_in) timing_q <= `CPPS_TIMING_RST;
      else timing_q <= timing_d;
   end

   function automatic logic [31:0] retry_cyc(input logic [1:0] f);
      case (f)
         2'h0: retry_cyc = 32'(RETRY0_CYC);
         2'h1: retry_cyc = 32'(RETRY1_CYC);
         2'h2: retry_cyc = 32'(RETRY2_CYC);
         default: retry_cyc = 32'(RETRY3_CYC);
      endcase
   endfunction : retry_cyc
   function automatic logic [31:0] ocmask_cyc(input logic [1:0] f);
      case (f)
         2'h0, 2'h1: ocmask_cyc = 32'(`CPPS_OC_MASK0_CYC);
         2'h2: ocmask_cyc = 32'(`CPPS_OC_MASK2_CYC);
         default: ocmask_cyc = 32'(`CPPS_OC_MASK3_CYC);
      endcase
   endfunction : ocmask_cyc

   // ==========================================================
   // Per-converter protection, index 0 intermediate, 1 core
   // ==========================================================
   logic [1:0] ov_hit, oc_hit, uv_hit, run_ok, entering;
   logic [1:0] ri_f [2];
   logic [1:0] om_f [2];
   assign ri_f[0] = timing_q[`CPPS_RI_INTER_HI:`CPPS_RI_INTER_LO];
   assign ri_f[1] = timing_q[`CPPS_RI_CORE_HI:`CPPS_RI_CORE_LO];
   assign om_f[0] = timing_q[`CPPS_OM_INTER_HI:`CPPS_OM_INTER_LO];
   assign om_f[1] = timing_q[`CPPS_OM_CORE_HI:`CPPS_OM_CORE_LO];
   // Over-voltage on either converter stops both
   assign ov_hit = {2{inter_ov_in | core_ov_in}};
   assign oc_hit = {core_oc_in, inter_oc_in};
   // Core/analog over-voltage is the forwarded detect into the intermediate
   assign uv_hit = {core_uv_in, inter_uv_in | core_ov_in | analog_ov_in};

   cpps_conv_t cst_q [2];
   cpps_conv_t cst_d [2];
   logic [31:0] oc_cnt_q [2];
   logic [31:0] oc_cnt_d [2];
   logic [31:0] uv_cnt_q [2];
   logic [31:0] uv_cnt_d [2];
   logic [31:0] rt_cnt_q [2];
   logic [31:0] rt_cnt_d [2];
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_conv
         // Mask counters filter glitches; retry timer paces restart attempts
         always_comb begin
            cst_d[gi] = cst_q[gi];
            oc_cnt_d[gi] = oc_hit[gi] ? oc_cnt_q[gi] + 32'h1 : 32'h0;
            uv_cnt_d[gi] = uv_hit[gi] ? uv_cnt_q[gi] + 32'h1 : 32'h0;
            rt_cnt_d[gi] = 32'h0;
            entering[gi] = 1'b0;
            case (cst_q[gi])
               CPPS_RUN: begin
                  if (ov_hit[gi]) begin
                     cst_d[gi] = CPPS_STOPPED;
                  end else if (oc_cnt_q[gi] >= ocmask_cyc(om_f[gi]) ||
                               uv_cnt_q[gi] >= 32'(`CPPS_UV_MASK_CYC)) begin
                     cst_d[gi] = CPPS_PROTECT;
                     entering[gi] = 1'b1;
                  end
               end
               CPPS_STOPPED: begin
                  if (!ov_hit[gi]) cst_d[gi] = CPPS_PROTECT;
               end
               CPPS_PROTECT: begin
                  rt_cnt_d[gi] = rt_cnt_q[gi] + 32'h1;
                  // Retry only when the fault has gone; otherwise wait another period
                  if (rt_cnt_q[gi] + 32'h1 >= retry_cyc(ri_f[gi])) begin
                     rt_cnt_d[gi] = 32'h0;
                     if (!oc_hit[gi] && !uv_hit[gi] && !ov_hit[gi]) cst_d[gi] = CPPS_RUN;
                  end
               end
               default: cst_d[gi] = CPPS_RUN;
            endcase
         end
         always_ff @(posedge clk_in) begin
            if (!nrst_in) begin
               cst_q[gi] <= CPPS_RUN;
               oc_cnt_q[gi] <= 32'h0;
               uv_cnt_q[gi] <= 32'h0;
               rt_cnt_q[gi] <= 32'h0;
            end else begin
               cst_q[gi] <= cst_d[gi];
               oc_cnt_q[gi] <= oc_cnt_d[gi];
               uv_cnt_q[gi] <= uv_cnt_d[gi];
               rt_cnt_q[gi] <= rt_cnt_d[gi];
            end
         end
         assign run_ok[gi] = (cst_q[gi] == CPPS_RUN) && !ov_hit[gi];
      end
   endgenerate

   // ==========================================================
   // Power sequencer
   // ==========================================================
   cpps_seq_t seq_q, seq_d;
   logic [31:0] tmr_q, tmr_d;
   logic [2:0] step_q, step_d;
   logic en_any;
   assign en_any = power_enable_a_in | power_enable_b_in;
   always_comb begin
      seq_d = seq_q;
      tmr_d = tmr_q + 32'h1;
      step_d = step_q;
      case (seq_q)
         CPPS_OFF, CPPS_KEEPALIVE: begin
            tmr_d = 32'h0;
            step_d = 3'h0;
            // An enable tied high starts as soon as supply is good
            if (battery_supply_ok_in && en_any && battery_above_reset_in) seq_d = CPPS_DIAG;
            else if (battery_supply_ok_in && keepalive_enable_in) seq_d = CPPS_KEEPALIVE;
            else seq_d = CPPS_OFF;
         end
         CPPS_DIAG: begin
            if (tmr_q + 32'h1 >= 32'(DIAG_CYC) && diag_pass_in) begin
               seq_d = CPPS_RAMP;
               tmr_d = 32'h0;
            end
         end
         CPPS_RAMP: begin
            // Fixed order, one rail per step
            if (tmr_q + 32'h1 >= 32'(STEP_CYC)) begin
               tmr_d = 32'h0;
               step_d = step_q + 3'h1;
               if (32'(step_q) + 32'h1 >= 32'(RAIL_COUNT)) seq_d = CPPS_HOLD;
            end
         end
         CPPS_HOLD: begin
            if (tmr_q + 32'h1 >= 32'(RST_HOLD_CYC)) seq_d = CPPS_ON;
         end
         CPPS_ON: tmr_d = 32'h0;
         CPPS_DOWN: begin
            // Rails drop in reverse order, each a step apart
            if (tmr_q + 32'h1 >= 32'(STEP_CYC)) begin
               tmr_d = 32'h0;
               if (step_q == 3'h0) seq_d = CPPS_OFF;
               else step_d = step_q - 3'h1;
            end
         end
         default: seq_d = CPPS_OFF;
      endcase
      // Dropped enables, low supply or reset level force power-down
      if (seq_q != CPPS_OFF && seq_q != CPPS_KEEPALIVE && seq_q != CPPS_DOWN &&
          (!en_any || !battery_above_reset_in || !battery_supply_ok_in)) begin
         seq_d = CPPS_DOWN;
         tmr_d = 32'h0;
      end
   end
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         seq_q <= CPPS_OFF;
         tmr_q <= 32'h0;
         step_q <= 3'h0;
      end else begin
         seq_q <= seq_d;
         tmr_q <= tmr_d;
         step_q <= step_d;
      end
   end

   // ==========================================================
   // Under-voltage reset stretch and status flags
   // ==========================================================
   logic [31:0] uvr_cnt_q, uvr_cnt_d;
   logic [1:0] stat_q, stat_d;
   logic uvr_hold;
   always_comb begin
      uvr_cnt_d = uvr_cnt_q == 32'h0 ? 32'h0 : uvr_cnt_q - 32'h1;
      if (uv_reset_enable_in && core_uv_in) uvr_cnt_d = 32'(RST_HOLD_CYC);
      // Set wins over clear
      stat_d = status_clr_in ? 2'h0 : stat_q;
      stat_d = stat_d | {core_ov_in | core_oc_in | core_uv_in, inter_ov_in | inter_oc_in | inter_uv_in};
   end
   assign uvr_hold = (uv_reset_enable_in && core_uv_in) || uvr_cnt_q != 32'h0;
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         uvr_cnt_q <= 32'h0;
         stat_q <= 2'h0;
      end else begin
         uvr_cnt_q <= uvr_cnt_d;
         stat_q <= stat_d;
      end
   end

   // ==========================================================
   // Registered outputs
   // ==========================================================
   logic [RAIL_COUNT-1:0] rails_d;
   logic powered;
   generate
      for (gi = 0; gi < RAIL_COUNT; gi++) begin : g_rail
         assign rails_d[gi] = (seq_d == CPPS_RAMP || seq_d == CPPS_DOWN) ? (32'(step_d) >= 32'(gi)) :
                              (seq_d == CPPS_HOLD || seq_d == CPPS_ON);
      end
   endgenerate
   assign powered = seq_d == CPPS_HOLD || seq_d == CPPS_ON;
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         reg_rdata_out <= 8'h00;
         fault_status_out <= 2'h0;
         inter_switch_en_out <= 1'b0;
         core_switch_en_out <= 1'b0;
         housekeeping_en_out <= 1'b0;
         rail_en_out <= '0;
         interrupt_out_n <= 1'b0;
         system_reset_out_n <= 1'b0;
         suspend_warning_n <= 1'b1;
      end else begin
         reg_rdata_out <= reg_addr_in == `CPPS_TIMING_ADDR ? timing_q : 8'h00;
         fault_status_out <= stat_d;
         inter_switch_en_out <= powered && cst_d[0] == CPPS_RUN && !ov_hit[0];
         core_switch_en_out <= powered && cst_d[1] == CPPS_RUN && !ov_hit[1];
         // Housekeeping stays on through power-down; once off, only keep-alive keeps it
         housekeeping_en_out <= seq_d != CPPS_OFF || keepalive_enable_in;
         rail_en_out <= rails_d;
         // Interrupt drops in the same edge the protect state is entered, never after
         interrupt_out_n <= powered && stat_d == 2'h0 && entering == 2'h0 && run_ok == 2'h3;
         system_reset_out_n <= seq_d == CPPS_ON && !uvr_hold;
         suspend_warning_n <= !io_first_low_level_in;
      end
   end
endmodule : cpps_core

// >>> design/cpps_defines.svh
// Register offsets, field positions, reset values and timing constants for the power sequencer
`ifndef CPPS_DEFINES_SVH
`define CPPS_DEFINES_SVH
`define CPPS_CLK_HZ 40000000
`define CPPS_TIMING_ADDR 6'h1B
`define CPPS_TIMING_RST 8'h44
`define CPPS_RI_CORE_HI 7
`define CPPS_RI_CORE_LO 6
`define CPPS_OM_CORE_HI 5
`define CPPS_OM_CORE_LO 4
`define CPPS_RI_INTER_HI 3
`define CPPS_RI_INTER_LO 2
`define CPPS_OM_INTER_HI 1
`define CPPS_OM_INTER_LO 0
// Times in microseconds (tenths where printed with a decimal)
`define CPPS_UV_MASK_US 92
`define CPPS_OC_MASK0_US 122
`define CPPS_OC_MASK2_US 610
`define CPPS_OC_MASK3_US 1098
`define CPPS_RETRY0_US_X10 156000
`define CPPS_RETRY1_US_X10 312000
`define CPPS_RETRY2_US_X10 1249000
`define CPPS_RETRY3_US_X10 2499000
`define CPPS_RST_HOLD_US 12000
// Mask times and retry intervals both round down
`define CPPS_UV_MASK_CYC ((`CPPS_UV_MASK_US * (`CPPS_CLK_HZ / 1000000)))
`define CPPS_OC_MASK0_CYC ((`CPPS_OC_MASK0_US * (`CPPS_CLK_HZ / 1000000)))
`define CPPS_OC_MASK2_CYC ((`CPPS_OC_MASK2_US * (`CPPS_CLK_HZ / 1000000)))
`define CPPS_OC_MASK3_CYC ((`CPPS_OC_MASK3_US * (`CPPS_CLK_HZ / 1000000)))
`define CPPS_RETRY0_CYC ((`CPPS_RETRY0_US_X10 / 10) * (`CPPS_CLK_HZ / 1000000))
`define CPPS_RETRY1_CYC ((`CPPS_RETRY1_US_X10 / 10) * (`CPPS_CLK_HZ / 1000000))
`define CPPS_RETRY2_CYC ((`CPPS_RETRY2_US_X10 / 10) * (`CPPS_CLK_HZ / 1000000))
`define CPPS_RETRY3_CYC ((`CPPS_RETRY3_US_X10 / 10) * (`CPPS_CLK_HZ / 1000000))
`define CPPS_RST_HOLD_CYC (`CPPS_RST_HOLD_US * (`CPPS_CLK_HZ / 1000000))
`endif

// >>> design/cpps_pkg.sv
// Types shared by the converter protection and power sequencer
package cpps_pkg;
   typedef enum logic [2:0] {
      CPPS_OFF,
      CPPS_KEEPALIVE,
      CPPS_DIAG,
      CPPS_RAMP,
      CPPS_HOLD,
      CPPS_ON,
      CPPS_DOWN
   } cpps_seq_t;
   typedef enum logic [1:0] {
      CPPS_RUN,
      CPPS_STOPPED,
      CPPS_PROTECT
   } cpps_conv_t;
endpackage : cpps_pkg

// >>> dv/cpps_host_model.sv
// Host controller model driving the enable pins and the keep-alive pin
`timescale 1ns/100ps
module cpps_host_model (
   input wire logic clk_in,
   input wire logic want_run_in,
   input wire logic use_b_in,
   input wire logic want_keep_in,
   input wire logic supply_above_in,
   input wire logic reset_n_in,
   output logic enable_a_out,
   output logic enable_b_out,
   output logic keepalive_out
);
   // ==========================================
   // Host decisions
   logic run_q = 1'h0;
   logic keep_q = 1'h0;
   logic run_d, keep_d;
   // Next values; keep-alive goes up before housekeeping can drop
   always_comb begin
      run_d = want_run_in && supply_above_in;
      keep_d = keep_q;
      if (!want_keep_in) begin
         keep_d = 1'h0;
      end else if (!reset_n_in || !want_run_in) begin
         keep_d = 1'h1;
      end
   end
   // Host pins change just after the clock edge
   always_ff @(posedge clk_in) begin
      run_q <= run_d;
      keep_q <= keep_d;
   end
   assign enable_a_out = run_q && !use_b_in;
   assign enable_b_out = run_q && use_b_in;
   assign keepalive_out = keep_q;
endmodule : cpps_host_model

// >>> dv/cpps_core_asserts.sv
// Port-level assertions for the converter protection and power sequencer
`timescale 1ns/100ps
module cpps_core_asserts #(
   parameter int RAIL_COUNT = 4,
   parameter int RST_HOLD_CYC = 480000
) (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic power_enable_a_in,
   input wire logic power_enable_b_in,
   input wire logic battery_above_reset_in,
   input wire logic io_first_low_level_in,
   input wire logic uv_reset_enable_in,
   input wire logic inter_ov_in,
   input wire logic core_ov_in,
   input wire logic core_uv_in,
   input wire logic [1:0] fault_status_out,
   input wire logic inter_switch_en_out,
   input wire logic core_switch_en_out,
   input wire logic housekeeping_en_out,
   input wire logic [RAIL_COUNT-1:0] rail_en_out,
   input wire logic interrupt_out_n,
   input wire logic system_reset_out_n,
   input wire logic suspend_warning_n
);
   // ==========================================
   // Reset-low length, saturating so it never wraps
   logic [19:0] low_cnt_q, low_cnt_d;
   always_comb begin
      low_cnt_d = low_cnt_q;
      if (system_reset_out_n) begin
         low_cnt_d = '0;
      end else if (low_cnt_q != 20'hFFFFF) begin
         low_cnt_d = low_cnt_q + 20'h1;
      end
   end
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         low_cnt_q <= '0;
      end else begin
         low_cnt_q <= low_cnt_d;
      end
   end
   // ==========================================
   // Checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   sequence s_both_stopped;
      !inter_switch_en_out && !core_switch_en_out;
   endsequence
   sequence s_warned;
      !system_reset_out_n && !interrupt_out_n;
   endsequence
   a_inter_ov_stop: assert property (inter_ov_in |=> s_both_stopped)
      else $error("inter over-voltage left a converter switching");
   a_core_ov_stop: assert property (core_ov_in |=> s_both_stopped)
      else $error("core over-voltage left a converter switching");
   a_uv_reset_now: assert property (uv_reset_enable_in && core_uv_in |=> !system_reset_out_n)
      else $error("core under-voltage did not pull reset");
   a_irq_before_protect: assert property (($fell(inter_switch_en_out) || $fell(core_switch_en_out))
      && !$past(inter_ov_in) && !$past(core_ov_in) |-> !interrupt_out_n)
      else $error("protect entered with interrupt high");
   a_flag_irq_low: assert property ((fault_status_out != 2'h0) [*2] |-> !interrupt_out_n)
      else $error("fault flag set but interrupt high");
   a_drop_warns: assert property (system_reset_out_n && !power_enable_a_in && !power_enable_b_in
      |=> s_warned)
      else $error("enables dropped without reset and interrupt");
   a_rails_after_rst: assert property (|($past(rail_en_out) & ~rail_en_out) |-> !system_reset_out_n)
      else $error("rail switched off while reset high");
   a_all_rails_up: assert property ($rose(system_reset_out_n) |-> &rail_en_out && housekeeping_en_out)
      else $error("reset released before all rails up");
   a_hold_time: assert property ($rose(system_reset_out_n) |-> low_cnt_q >= RST_HOLD_CYC - 1)
      else $error("reset released too early");
   a_suspend_warn: assert property (io_first_low_level_in && system_reset_out_n |=> !suspend_warning_n)
      else $error("no suspend warning on low io level");
   a_low_supply_rst: assert property (!battery_above_reset_in |=> !system_reset_out_n)
      else $error("reset high with supply below threshold");
endmodule : cpps_core_asserts

bind cpps_core cpps_core_asserts #(.RAIL_COUNT(RAIL_COUNT), .RST_HOLD_CYC(RST_HOLD_CYC)) u_asserts (.*);

// >>> dv/cpps_testbench.sv
// Self-checking bench for the converter protection and power sequencer
`timescale 1ns/100ps
module testbench;
   localparam int HOLD = 50;
   logic clk_in, nrst_in, power_enable_a_in, power_enable_b_in, keepalive_enable_in;
   logic battery_supply_ok_in, battery_above_reset_in, io_first_low_level_in, diag_pass_in;
   logic uv_reset_enable_in, inter_ov_in, inter_oc_in, inter_uv_in, core_ov_in, core_oc_in;
   logic core_uv_in, analog_ov_in, reg_wr_in, status_clr_in, run, use_b, keep;
   logic [5:0] reg_addr_in;
   logic [7:0] reg_wdata_in, reg_rdata_out;
   logic [1:0] fault_status_out;
   logic inter_switch_en_out, core_switch_en_out, housekeeping_en_out;
   logic interrupt_out_n, system_reset_out_n, suspend_warning_n;
   logic [3:0] rail_en_out;
   int err_total, total_checks, n, k;
   // Short counts keep the run brief
   cpps_core #(.STEP_CYC(8), .DIAG_CYC(8), .RST_HOLD_CYC(HOLD), .RETRY0_CYC(20), .RETRY1_CYC(30),
      .RETRY2_CYC(40), .RETRY3_CYC(50)) dut (.*);
   cpps_host_model host (.clk_in(clk_in), .want_run_in(run), .use_b_in(use_b), .want_keep_in(keep),
      .supply_above_in(battery_above_reset_in), .reset_n_in(system_reset_out_n),
      .enable_a_out(power_enable_a_in), .enable_b_out(power_enable_b_in), .keepalive_out(keepalive_enable_in));
   // ==========================================
   // Clock and helpers
   initial begin
      clk_in = 1'h0;
      forever #12.5 clk_in = ~clk_in;
   end
   task step(input int c);
      repeat (c) @(posedge clk_in);
      #2;
   endtask : step
   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Bounded wait while a level holds; a stuck design ends it
   task automatic cnt(ref logic s, input logic v, output int c);
      c = 0;
      while (s === v && c < 60000) begin
         step(1);
         c++;
      end
   endtask : cnt
   task wr(input logic [5:0] a, input logic [7:0] d);
      reg_wr_in = 1'h1;
      reg_addr_in = a;
      reg_wdata_in = d;
      step(1);
      reg_wr_in = 1'h0;
   endtask : wr
   task rd(input logic [5:0] a, input logic [7:0] e);
      reg_addr_in = a;
      step(2);
      chk(reg_rdata_out, e);
   endtask : rd
   task wrap_up;
      if (err_total == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : wrap_up
   // ==========================================
   // Scenarios
   task t_regs;
      rd(6'h1B, 8'h44);
      wr(6'h1A, 8'hFF);
      rd(6'h1A, 8'h00);
      wr(6'h1B, 8'hD2);
      rd(6'h1B, 8'hD2);
   endtask : t_regs
   task t_keep;
      keep = 1'h1;
      step(20);
      chk({housekeeping_en_out, rail_en_out}, 5'h10);
      keep = 1'h0;
      step(4);
   endtask : t_keep
   // Supply rising with an enable held starts diagnosis; a failing diagnosis stalls the ramp
   task t_tied;
      battery_supply_ok_in = 1'h0;
      diag_pass_in = 1'h0;
      run = 1'h1;
      step(20);
      chk(rail_en_out, 4'h0);
      battery_supply_ok_in = 1'h1;
      step(30);
      chk({housekeeping_en_out, rail_en_out}, 5'h10);
      diag_pass_in = 1'h1;
   endtask : t_tied
   // Rails must come up lowest first, housekeeping already on
   task t_up(input logic b);
      use_b = b;
      run = 1'h1;
      n = 0;
      k = 0;
      while (!system_reset_out_n && n < 3000) begin
         step(1);
         n++;
         if (interrupt_out_n) k++;
         if ((rail_en_out & (rail_en_out + 4'h1)) != 0 || (rail_en_out != 0 && !housekeeping_en_out)) n = 9000;
      end
      chk(rail_en_out, 4'hF);
      chk(k >= HOLD - 1 && k <= HOLD + 2, 1'h1);
   endtask : t_up
   task t_inter;
      inter_uv_in = 1'h1;
      step(3600);
      inter_uv_in = 1'h0;
      chk(inter_switch_en_out, 1'h1);
      step(2);
      inter_uv_in = 1'h1;
      cnt(inter_switch_en_out, 1'h1, n);
      chk(n >= 3678 && n <= 3683, 1'h1);
      inter_uv_in = 1'h0;
      cnt(inter_switch_en_out, 1'h0, n);
      inter_oc_in = 1'h1;
      cnt(inter_switch_en_out, 1'h1, n);
      chk(n >= 24398 && n <= 24403, 1'h1);
      chk({interrupt_out_n, fault_status_out[0]}, 2'h1);
      inter_oc_in = 1'h0;
      cnt(inter_switch_en_out, 1'h0, n);
      chk(n >= 17 && n <= 22, 1'h1);
   endtask : t_inter
   task t_core;
      // Under-voltage is no reset cause until the option is set
      core_uv_in = 1'h1;
      step(2);
      chk(system_reset_out_n, 1'h1);
      core_uv_in = 1'h0;
      uv_reset_enable_in = 1'h1;
      core_oc_in = 1'h1;
      cnt(core_switch_en_out, 1'h1, n);
      chk(n >= 4878 && n <= 4883, 1'h1);
      core_oc_in = 1'h0;
      cnt(core_switch_en_out, 1'h0, n);
      chk(n >= 47 && n <= 52, 1'h1);
      core_uv_in = 1'h1;
      step(1);
      chk(system_reset_out_n, 1'h0);
      step(100);
      core_uv_in = 1'h0;
      cnt(system_reset_out_n, 1'h0, n);
      chk(n >= HOLD - 1 && n <= HOLD + 2, 1'h1);
      rd(6'h1B, 8'hD2);
   endtask : t_core
   task t_ov;
      inter_ov_in = 1'h1;
      step(1);
      chk({inter_switch_en_out, core_switch_en_out}, 2'h0);
      inter_ov_in = 1'h0;
      step(200);
      core_ov_in = 1'h1;
      step(1);
      chk({inter_switch_en_out, core_switch_en_out}, 2'h0);
      core_ov_in = 1'h0;
      step(200);
      analog_ov_in = 1'h1;
      cnt(inter_switch_en_out, 1'h1, n);
      chk(n >= 3678 && n <= 3683, 1'h1);
      analog_ov_in = 1'h0;
      step(200);
      status_clr_in = 1'h1;
      step(1);
      status_clr_in = 1'h0;
      step(1);
      chk(fault_status_out, 2'h0);
   endtask : t_ov
   // Rails must fall highest first, housekeeping kept
   task t_down;
      keep = 1'h1;
      run = 1'h0;
      k = 0;
      n = 0;
      while (rail_en_out != 0 && n < 500) begin
         step(1);
         n++;
         if ((rail_en_out & (rail_en_out + 4'h1)) != 0) k++;
      end
      chk({k != 0, rail_en_out, housekeeping_en_out, interrupt_out_n}, 7'h02);
   endtask : t_down
   task t_supply;
      io_first_low_level_in = 1'h1;
      step(1);
      chk(suspend_warning_n, 1'h0);
      battery_above_reset_in = 1'h0;
      step(1);
      chk(system_reset_out_n, 1'h0);
      step(100);
      chk({rail_en_out, housekeeping_en_out}, 5'h01);
   endtask : t_supply
   // ==========================================
   // Main sequence and watchdog
   initial begin
      nrst_in = 1'h0;
      {battery_supply_ok_in, battery_above_reset_in, diag_pass_in} = 3'h7;
      {io_first_low_level_in, uv_reset_enable_in, reg_wr_in, status_clr_in, run, use_b, keep} = '0;
      {inter_ov_in, inter_oc_in, inter_uv_in, core_ov_in, core_oc_in, core_uv_in, analog_ov_in} = '0;
      reg_addr_in = 6'h00;
      reg_wdata_in = 8'h00;
      err_total = 0;
      total_checks = 0;
      step(4);
      nrst_in = 1'h1;
      t_regs();
      t_keep();
      t_tied();
      t_up(1'h0);
      t_inter();
      t_core();
      t_ov();
      t_down();
      t_up(1'h1);
      t_supply();
      wrap_up();
   end
   initial begin
      repeat (90000) @(posedge clk_in);
      err_total++;
      wrap_up();
   end
endmodule : testbench
